// ### inc/ssf_consts.vh
// constants for the serial transceiver digital core
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH

// bus register byte offsets
`define SSF_ADDR_CTRL 4'h0
`define SSF_ADDR_STATUS 4'h4
`define SSF_ADDR_RATIO 4'h8
`define SSF_ADDR_FRAMES 4'hc
`define SSF_RESP_OKAY 2'h0
`define SSF_RESP_SLVERR 2'h2

// control register field positions
`define SSF_CTL_BYPASS 0
`define SSF_CTL_FAR 1
`define SSF_CTL_NEAR 2
`define SSF_CTL_SNEAR 3
`define SSF_CTL_RXCLKTX 4
`define SSF_CTL_RXREF 5
`define SSF_CTL_LOSDIS_N 6
`define SSF_CTL_RATE_HI 7
`define SSF_CTL_RSEL_LO 8
`define SSF_CTL_RSEL_HI 10
`define SSF_CTL_WIDTH 11
`define SSF_CTL_RESET 11'h000

// framing pattern bytes
`define SSF_A1 8'hf6
`define SSF_A2 8'h28

// bit period in core cycles for each line rate (model of the multiplied clock), then byte bit counts
`define SSF_BIT_DIV_HI 6'h04
`define SSF_BIT_DIV_LO 6'h10
`define SSF_BYTE_BITS 3'h7
`define SSF_HALF_BYTE 3'h3

// loss-of-signal thresholds in bit times / transitions
`define SSF_LOS_RUN 8'h80
`define SSF_LOS_WIN 7'h7f
`define SSF_LOS_TRANS 5'h10

// multiplier feedback divide ratios by selector, high and low rate
`define SSF_DIV_HI_0 6'h08
`define SSF_DIV_HI_1 6'h0c
`define SSF_DIV_HI_2 6'h10
`define SSF_DIV_HI_3 6'h20
`define SSF_DIV_LO_0 6'h02
`define SSF_DIV_LO_1 6'h03
`define SSF_DIV_LO_2 6'h04
`define SSF_DIV_LO_3 6'h08

`endif

// ### design/ssf_serdes_core.v
// serdes framer core: serializer, deserializer, framing, loss of signal, loopbacks
`timescale 1ns/100ps
`include "ssf_consts.vh"

module ssf_serdes_core (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // transmit byte side
    input wire [7:0] tx_parallel_in,
    input wire tx_byte_clk_in,
    output wire tx_byte_clk_out,
    // serial transmit side
    output wire tx_serial_out,
    output wire tx_serial_clk_out,
    // serial receive side
    input wire rx_serial_in,
    input wire rx_serial_clk_in,
    // receive byte side
    output wire [7:0] rx_parallel_out,
    output wire rx_byte_clk_out,
    output wire frame_pulse,
    input wire framing_hunt,
    // loss of signal straps and state
    input wire los_force_ttl,
    input wire los_force_pecl,
    output wire losActive,
    output wire refFromRx,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // control register and its fields
    reg [`SSF_CTL_WIDTH-1:0] ctrl_q;
    wire recoveryBypass = ctrl_q[`SSF_CTL_BYPASS];
    wire farLoopEn = ctrl_q[`SSF_CTL_FAR];
    wire nearLoopEn = ctrl_q[`SSF_CTL_NEAR];
    wire serialNearLoopEn = ctrl_q[`SSF_CTL_SNEAR];
    wire rxClockTxMode = ctrl_q[`SSF_CTL_RXCLKTX];
    wire rxRefMode = ctrl_q[`SSF_CTL_RXREF];
    wire losDetectDisableN = ctrl_q[`SSF_CTL_LOSDIS_N];
    wire rateHiSel = ctrl_q[`SSF_CTL_RATE_HI];
    wire [2:0] refRatioSel = ctrl_q[`SSF_CTL_RSEL_HI:`SSF_CTL_RSEL_LO];

    // divide ratio lookup, unknown selector codes fall back to the first ratio
    reg [5:0] divRatio;
    always @* begin
        case ({rateHiSel, refRatioSel})
            4'h8: divRatio = `SSF_DIV_HI_0;
            4'h9: divRatio = `SSF_DIV_HI_1;
            4'ha: divRatio = `SSF_DIV_HI_2;
            4'hb: divRatio = `SSF_DIV_HI_3;
            4'h0: divRatio = `SSF_DIV_LO_0;
            4'h1: divRatio = `SSF_DIV_LO_1;
            4'h2: divRatio = `SSF_DIV_LO_2;
            4'h3: divRatio = `SSF_DIV_LO_3;
            default: divRatio = rateHiSel ? `SSF_DIV_HI_0 : `SSF_DIV_LO_0;
        endcase
    end

    // multiplied clock model: bit phase counter giving rise and fall enables
    reg [5:0] cmuPhase_q;
    wire [5:0] bitDiv = rateHiSel ? `SSF_BIT_DIV_HI : `SSF_BIT_DIV_LO;
    wire cmuRise = (cmuPhase_q == 6'h00);
    wire cmuFall = (cmuPhase_q == {1'b0, bitDiv[5:1]});
    always @(posedge core_clk) begin
        if (reset || cmuPhase_q >= bitDiv - 6'h01) begin
            cmuPhase_q <= 6'h00;
        end else begin
            cmuPhase_q <= cmuPhase_q + 6'h01;
        end
    end

    // external serial clock edges; inputs are synchronous so one history flop suffices
    reg extClkPrev_q;
    reg txByteClkPrev_q;
    wire extRise = rx_serial_clk_in & ~extClkPrev_q;
    wire extFall = ~rx_serial_clk_in & extClkPrev_q;
    wire txByteEdge = tx_byte_clk_in & ~txByteClkPrev_q;
    always @(posedge core_clk) begin
        if (reset) begin
            extClkPrev_q <= 1'b0;
            txByteClkPrev_q <= 1'b0;
        end else begin
            extClkPrev_q <= rx_serial_clk_in;
            txByteClkPrev_q <= tx_byte_clk_in;
        end
    end

    // loss-of-signal state, needed early for clock selection
    reg losDet_q;
    wire losForced = ~(los_force_ttl ^ los_force_pecl);
    assign losActive = (losDet_q & ~losDetectDisableN) | losForced;

    // receive line clock: external only in bypass without loss, else recovered/multiplied
    wire useExtRx = recoveryBypass & ~losActive;
    wire rxLineRise = useExtRx ? extRise : cmuRise;
    wire rxLineFall = useExtRx ? extFall : cmuFall;

    // transmit bit clock: in far loop or loop timing the external clock when bypassed (kept during loss), else multiplier
    wire txFromRx = farLoopEn | rxClockTxMode;
    wire txRise = txFromRx ? (recoveryBypass ? extRise : cmuRise) : cmuRise;
    wire txFall = txFromRx ? (recoveryBypass ? extFall : cmuFall) : cmuFall;

    // multiplier reference select, self-reference prevented in near loop only, not in serial near loop
    assign refFromRx = rxRefMode & ~losActive & ~nearLoopEn;

    // transmit byte capture
    reg [7:0] txHold_q;
    always @(posedge core_clk) begin
        if (reset) begin
            txHold_q <= 8'h00;
        end else if (txByteEdge) begin
            txHold_q <= tx_parallel_in;
        end
    end

    // divide-by-eight transmit byte clock from the multiplied clock
    reg [2:0] cmuBitCnt_q;
    reg txByteClkOut_q;
    always @(posedge core_clk) begin
        if (reset) begin
            cmuBitCnt_q <= 3'h0;
            txByteClkOut_q <= 1'b0;
        end else if (cmuRise) begin
            cmuBitCnt_q <= cmuBitCnt_q + 3'h1;
            txByteClkOut_q <= (cmuBitCnt_q <= `SSF_HALF_BYTE) ? 1'b1 : 1'b0;
        end
    end
    assign tx_byte_clk_out = txByteClkOut_q;

    // serializer, msb first; a new byte is loaded every eighth launch
    reg [2:0] txBitCnt_q;
    reg [7:0] txShift_q;
    reg serBit_q;
    wire serNext = (txBitCnt_q == 3'h0) ? txHold_q[7] : txShift_q[7];
    always @(posedge core_clk) begin
        if (reset) begin
            txBitCnt_q <= 3'h0;
            txShift_q <= 8'h00;
            serBit_q <= 1'b0;
        end else if (txFall) begin
            serBit_q <= serNext;
            txBitCnt_q <= txBitCnt_q + 3'h1;
            if (txBitCnt_q == 3'h0) begin
                txShift_q <= {txHold_q[6:0], 1'b0};
            end else begin
                txShift_q <= {txShift_q[6:0], 1'b0};
            end
        end
    end

    // serial outputs: far loop repeats the line, otherwise the serializer
    reg txSerialOut_q;
    reg txSerialClk_q;
    always @(posedge core_clk) begin
        if (reset) begin
            txSerialOut_q <= 1'b0;
            txSerialClk_q <= 1'b0;
        end else begin
            if (txRise) begin
                txSerialClk_q <= 1'b1;
            end else if (txFall) begin
                txSerialClk_q <= 1'b0;
            end
            if (txFall) begin
                txSerialOut_q <= farLoopEn ? rx_serial_in : serNext;
            end
        end
    end
    assign tx_serial_out = txSerialOut_q;
    assign tx_serial_clk_out = txSerialClk_q;

    // receive bit source: near loop taps serializer, serial near loop feeds recovery input
    reg rxBit;
    reg rxTick;
    always @* begin
        if (nearLoopEn) begin
            rxBit = serNext;
            rxTick = txFall;
        end else if (recoveryBypass) begin
            rxBit = rx_serial_in;
            rxTick = rxLineRise;
        end else begin
            rxBit = serialNearLoopEn ? txSerialOut_q : rx_serial_in;
            rxTick = rxLineRise;
        end
    end

    // loss-of-signal detector: run length and transition window counters
    reg lastBit_q;
    reg [7:0] runLen_q;
    reg [6:0] winCnt_q;
    reg [4:0] transCnt_q;
    wire transition = rxBit ^ lastBit_q;
    always @(posedge core_clk) begin
        if (reset) begin
            lastBit_q <= 1'b0;
            runLen_q <= 8'h00;
            winCnt_q <= 7'h00;
            transCnt_q <= 5'h00;
            losDet_q <= 1'b0;
        end else if (rxTick) begin
            lastBit_q <= rxBit;
            if (transition) begin
                runLen_q <= 8'h00;
            end else if (runLen_q != 8'hff) begin
                runLen_q <= runLen_q + 8'h01;
            end
            if (!losDet_q && !transition && runLen_q >= `SSF_LOS_RUN) begin
                losDet_q <= 1'b1;
                winCnt_q <= 7'h00;
                transCnt_q <= 5'h00;
            end else if (losDet_q) begin
                // window restarts every 128 bits; loss clears on a transition once the count reaches threshold
                if (transition && transCnt_q >= `SSF_LOS_TRANS) begin
                    losDet_q <= 1'b0;
                end
                if (winCnt_q == `SSF_LOS_WIN) begin
                    winCnt_q <= 7'h00;
                    transCnt_q <= 5'h00;
                end else begin
                    winCnt_q <= winCnt_q + 7'h01;
                    if (transition) begin
                        transCnt_q <= transCnt_q + 5'h01;
                    end
                end
            end
        end
    end

    // deserializer with frame hunter over the last 48 received bits
    reg [47:0] rxShift_q;
    reg [2:0] rxBitCnt_q;
    reg [7:0] rxByte_q;
    reg framePulse_q;
    reg rxByteClk_q;
    reg [15:0] frameCount_q;
    wire [47:0] rxShiftNext = {rxShift_q[46:0], rxBit};
    wire patternHit = (rxShiftNext == {`SSF_A1, `SSF_A1, `SSF_A1,
                                      `SSF_A2, `SSF_A2, `SSF_A2});
    wire realign = framing_hunt & patternHit;
    wire byteDone = realign | (rxBitCnt_q == `SSF_BYTE_BITS);
    always @(posedge core_clk) begin
        if (reset) begin
            rxShift_q <= 48'h000000000000;
            rxBitCnt_q <= 3'h0;
            rxByte_q <= 8'h00;
            framePulse_q <= 1'b0;
            rxByteClk_q <= 1'b0;
            frameCount_q <= 16'h0000;
        end else if (rxTick) begin
            rxShift_q <= rxShiftNext;
            rxBitCnt_q <= byteDone ? 3'h0 : rxBitCnt_q + 3'h1;
            rxByteClk_q <= (byteDone || rxBitCnt_q < `SSF_HALF_BYTE) ? 1'b1 : 1'b0;
            if (byteDone) begin
                rxByte_q <= losActive ? 8'h00 : rxShiftNext[7:0];
                framePulse_q <= realign;
                if (realign) begin
                    frameCount_q <= frameCount_q + 16'h0001;
                end
            end
        end
    end
    assign rx_parallel_out = rxByte_q;
    assign frame_pulse = framePulse_q;
    assign rx_byte_clk_out = rxByteClk_q;

    // axi4-lite write: address and data latched in either order, then one response
    reg awHeld_q;
    reg wHeld_q;
    reg [3:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg bValid_q;
    reg [1:0] bResp_q;
    assign s_axi_awready = ~awHeld_q & ~bValid_q;
    assign s_axi_wready = ~wHeld_q & ~bValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
    always @(posedge core_clk) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= `SSF_RESP_OKAY;
            ctrl_q <= `SSF_CTL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                if (awAddr_q == `SSF_ADDR_CTRL) begin
                    bResp_q <= `SSF_RESP_OKAY;
                    if (wStrb_q[0]) begin
                        ctrl_q[7:0] <= wData_q[7:0];
                    end
                    if (wStrb_q[1]) begin
                        ctrl_q[`SSF_CTL_WIDTH-1:8] <= wData_q[`SSF_CTL_WIDTH-1:8];
                    end
                end else if (awAddr_q == `SSF_ADDR_STATUS || awAddr_q == `SSF_ADDR_RATIO ||
                             awAddr_q == `SSF_ADDR_FRAMES) begin
                    bResp_q <= `SSF_RESP_OKAY; // read-only, write ignored
                end else begin
                    bResp_q <= `SSF_RESP_SLVERR;
                end
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    // axi4-lite read: one cycle to answer, data held until taken
    reg rValid_q;
    reg [31:0] rData_q;
    reg [1:0] rResp_q;
    assign s_axi_arready = ~rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    always @(posedge core_clk) begin
        if (reset) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= `SSF_RESP_OKAY;
        end else if (s_axi_arvalid && !rValid_q) begin
            rValid_q <= 1'b1;
            rResp_q <= `SSF_RESP_OKAY;
            case (s_axi_araddr)
                `SSF_ADDR_CTRL: rData_q <= {21'h000000, ctrl_q};
                `SSF_ADDR_STATUS: rData_q <= {27'h0000000, framing_hunt, refFromRx,
                                              losForced, losDet_q, losActive};
                `SSF_ADDR_RATIO: rData_q <= {26'h0000000, divRatio};
                `SSF_ADDR_FRAMES: rData_q <= {16'h0000, frameCount_q};
                default: begin
                    rData_q <= 32'h00000000;
                    rResp_q <= `SSF_RESP_SLVERR;
                end
            endcase
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

endmodule // ssf_serdes_core

// ### tb/ssf_serdes_properties.sv
// port assertions for the serdes framer core
`timescale 1ns/100ps

module ssf_serdes_properties (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // serial transmit
    input wire tx_serial_out,
    input wire tx_serial_clk_out,
    // receive byte side
    input wire [7:0] rx_parallel_out,
    input wire rx_byte_clk_out,
    input wire frame_pulse,
    input wire framing_hunt,
    // loss of signal
    input wire los_force_ttl,
    input wire los_force_pecl,
    input wire losActive,
    input wire refFromRx
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // bytes are blanked at the first byte update taken during loss
    AST_LOS_ZERO: assert property (
        $rose(rx_byte_clk_out) && losActive && $past(losActive) |-> rx_parallel_out == 8'h00)
        else $error("receive byte not zero during loss of signal");
    AST_LOS_FORCE: assert property (
        los_force_ttl == los_force_pecl |-> losActive)
        else $error("equal force straps did not force loss of signal");
    // the multiplier must drop the receive reference during loss of signal
    AST_REF_OFF: assert property (
        losActive |-> !refFromRx)
        else $error("receive reference kept during loss of signal");
    AST_PULSE_HUNT: assert property (
        $rose(frame_pulse) |-> $past(framing_hunt))
        else $error("frame pulse without hunt");
    AST_PULSE_BYTE: assert property (
        $rose(frame_pulse) |-> rx_parallel_out == 8'hf6 - 8'hce && rx_byte_clk_out)
        else $error("frame pulse not with aligned second pattern byte");
    AST_PULSE_END: assert property (
        $fell(frame_pulse) |-> $rose(rx_byte_clk_out))
        else $error("frame pulse ended off a byte boundary");
    // after loss clears the byte is restored at the next byte boundary
    AST_RX_STEP: assert property (
        !$stable(rx_parallel_out) && !losActive && !$past(losActive) && !$past(losActive, 2)
        |-> $rose(rx_byte_clk_out) || $rose(frame_pulse))
        else $error("receive byte changed without byte clock rise");
    AST_TX_ON_LOW: assert property (
        !$stable(tx_serial_out) |-> !tx_serial_clk_out)
        else $error("serial bit launched while serial clock high");

    // main scenarios reached
    COV_FRAME: cover property ($rose(frame_pulse));
    COV_LOS_SET: cover property ($rose(losActive));
    COV_LOS_CLR: cover property ($fell(losActive));
endmodule // ssf_serdes_properties

bind ssf_serdes_core ssf_serdes_properties ssf_serdes_properties_inst (.core_clk, .reset,
    .tx_serial_out, .tx_serial_clk_out, .rx_parallel_out, .rx_byte_clk_out, .frame_pulse,
    .framing_hunt, .los_force_ttl, .los_force_pecl, .losActive, .refFromRx);

// ### tb/ssf_framer_model.sv
// behavioural network framer on the byte side of the serdes core
`timescale 1ns/100ps

module ssf_framer_model (
    // clocks
    input wire core_clk,
    input wire tx_byte_clk_out,
    // transmit byte side
    output wire tx_byte_clk_in,
    output logic [7:0] tx_parallel_in = 8'h00,
    // receive byte side
    input wire [7:0] rx_parallel_out,
    input wire rx_byte_clk_out,
    input wire frame_pulse,
    output logic framing_hunt = 1'b0,
    // bench control and status
    input wire huntReq,
    output logic [7:0] pulseByte = 8'h00,
    output int frameCount = 0
);
    // two filler bytes then three first and three second pattern bytes
    localparam logic [63:0] PATTERN = 64'h1122f6f6f6282828;
    logic [2:0] slot = 3'h0;
    logic pulsePrev = 1'b0;

    // byte clock looped straight back as transmit timing
    assign tx_byte_clk_in = tx_byte_clk_out;
    // new byte on the falling side so it is steady at the rise
    always @(negedge tx_byte_clk_out) begin
        tx_parallel_in <= PATTERN[8 * (3'h7 - slot) +: 8];
        slot <= slot + 3'h1;
        // hunt only rises at loop head, two filler bytes before the first pattern byte
        if (!huntReq)
            framing_hunt <= 1'b0;
        else if (slot == 3'h0)
            framing_hunt <= 1'b1;
    end

    // take the byte at the pulse rise; a realign may land while the byte clock is high
    always @(posedge core_clk) begin
        pulsePrev <= frame_pulse;
        if (frame_pulse && !pulsePrev && rx_byte_clk_out) begin
            pulseByte <= rx_parallel_out;
            frameCount <= frameCount + 1;
        end
    end
endmodule // ssf_framer_model

// ### tb/tb_top.sv
// self-checking bench for the serdes framer core
`timescale 1ns/100ps
`include "ssf_consts.vh"

module tb_top;
    logic core_clk = 1'b0, reset = 1'b1;
    logic rx_serial_in = 1'b0, rx_serial_clk_in = 1'b0;
    logic los_force_ttl = 1'b0, los_force_pecl = 1'b1, huntReq = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire [7:0] tx_parallel_in, rx_parallel_out, pulseByte;
    wire tx_byte_clk_in, framing_hunt, tx_byte_clk_out, tx_serial_out, tx_serial_clk_out;
    wire rx_byte_clk_out, frame_pulse, losActive, refFromRx;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int frameCount, mismatches = 0, checkCount = 0, cycles = 0, txRises = 0;
    logic [15:0] txShift = 16'h0;
    logic txClkPrev = 1'b0, seenF628 = 1'b0;

    ssf_serdes_core ssf_serdes_core_inst (.core_clk, .reset, .tx_parallel_in, .tx_byte_clk_in,
        .tx_byte_clk_out, .tx_serial_out, .tx_serial_clk_out, .rx_serial_in, .rx_serial_clk_in,
        .rx_parallel_out, .rx_byte_clk_out, .frame_pulse, .framing_hunt, .los_force_ttl,
        .los_force_pecl, .losActive, .refFromRx, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ssf_framer_model ssf_framer_model_inst (.core_clk, .tx_byte_clk_out, .tx_byte_clk_in,
        .tx_parallel_in, .rx_parallel_out, .rx_byte_clk_out, .frame_pulse, .framing_hunt,
        .huntReq, .pulseByte, .frameCount);

    // 200 MHz core clock
    initial forever #2.5 core_clk = ~core_clk;

    // serial wire watched at clock rise, where its bit is steady
    always @(posedge core_clk) begin
        txClkPrev <= tx_serial_clk_out;
        if (tx_serial_clk_out && !txClkPrev) begin
            txShift <= {txShift[14:0], tx_serial_out};
            txRises++;
        end
        if (txShift == 16'hf628)
            seenF628 <= 1'b1;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // bready held from the start; loop ends on the response edge
    task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
        bit done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk(s_axi_bresp, `SSF_RESP_OKAY);
                done = 1'b1;
            end
        end
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] e);
        bit done = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata & mask, e);
                done = 1'b1;
            end
        end
    endtask

    // msb first, 4 cycles a bit; the link clock only moves when asked
    task automatic sendBits(input logic [63:0] v, input bit withClk);
        for (int i = 63; i >= 0; i--) begin
            rx_serial_in <= v[i];
            rx_serial_clk_in <= 1'b0;
            cyc(2);
            rx_serial_clk_in <= withClk;
            cyc(2);
        end
    endtask

    task automatic toggles(input int n);
        repeat (n) begin
            rx_serial_in <= ~rx_serial_in;
            cyc(8);
        end
    endtask

    task automatic tRegs;
        logic [31:0] ratio [0:3] = '{32'h8, 32'hc, 32'h10, 32'h20};
        rdChk(`SSF_ADDR_CTRL, 32'hffffffff, 32'h0);
        for (int k = 0; k < 4; k++) begin
            axiWr(`SSF_ADDR_CTRL, 32'h80 | (k << 8));
            rdChk(`SSF_ADDR_RATIO, 32'hffffffff, ratio[k]);
        end
        $display("test regs done");
    endtask

    task automatic tLos;
        axiWr(`SSF_ADDR_CTRL, 32'ha0);
        toggles(30);
        chk(refFromRx, 1'b1);
        cyc(480);
        chk(losActive, 1'b0);
        cyc(80);
        chk(losActive, 1'b1);
        chk(rx_parallel_out, 8'h00);
        chk(refFromRx, 1'b0);
        rdChk(`SSF_ADDR_STATUS, 32'h1, 32'h1);
        toggles(10);
        chk(losActive, 1'b1);
        toggles(40);
        chk(losActive, 1'b0);
        axiWr(`SSF_ADDR_CTRL, 32'he4);
        chk(refFromRx, 1'b0);
        axiWr(`SSF_ADDR_CTRL, 32'hc0);
        cyc(600);
        chk(losActive, 1'b0);
        los_force_ttl <= 1'b1;
        cyc(2);
        chk(losActive, 1'b1);
        los_force_pecl <= 1'b0;
        cyc(2);
        chk(losActive, 1'b0);
        $display("test loss done");
    endtask

    task automatic tFrame(input logic [31:0] ctl);
        int n;
        axiWr(`SSF_ADDR_CTRL, ctl);
        huntReq <= 1'b1;
        seenF628 <= 1'b0;
        cyc(900);
        chk(frameCount >= 2, 1'b1);
        chk(pulseByte, `SSF_A2);
        chk(seenF628, 1'b1);
        huntReq <= 1'b0;
        cyc(300);
        n = frameCount;
        cyc(900);
        chk(frameCount, n);
        $display("test frame done");
    endtask

    task automatic tBypass;
        int n;
        axiWr(`SSF_ADDR_CTRL, 32'hc1);
        huntReq <= 1'b1;
        cyc(300);
        n = frameCount;
        sendBits(64'h55f6f62828285555, 1'b1);
        chk(frameCount, n);
        sendBits(64'hf6f6f62828285555, 1'b1);
        chk(frameCount, n + 1);
        chk(pulseByte, `SSF_A2);
        $display("test bypass done");
    endtask

    task automatic tSplit;
        int n;
        axiWr(`SSF_ADDR_CTRL, 32'hc6);
        n = frameCount;
        cyc(80);
        seenF628 <= 1'b0;
        sendBits(64'h00f6280000000000, 1'b0);
        chk(seenF628, 1'b1);
        cyc(600);
        chk(frameCount > n, 1'b1);
        $display("test split done");
    endtask

    task automatic tLoopTime;
        axiWr(`SSF_ADDR_CTRL, 32'hd1);
        // one external clock pulse parks the serial clock low before counting
        rx_serial_clk_in <= 1'b1;
        cyc(4);
        rx_serial_clk_in <= 1'b0;
        cyc(16);
        txRises = 0;
        sendBits(64'h0, 1'b1);
        cyc(20);
        chk(txRises, 64);
        $display("test loop timing done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        cyc(12);
        reset <= 1'b0;
        tRegs();
        tLos();
        tFrame(32'hc4);
        tFrame(32'hc8);
        tBypass();
        tSplit();
        tLoopTime();
        summarize();
    end
endmodule // tb_top
